// file: logic/dcc_channel.sv
// One comparator channel: synchroniser, edge flags, control storage
module dcc_channel (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       cmp_raw,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic [7:0]      ctrl_rd,
  output logic            routed_out,
  output logic [1:0]      pos_hyst_sel,
  output logic [1:0]      neg_hyst_sel,
  output logic            settling
);
  logic       sync1_reg;
  logic       sync2_reg;
  logic       prev_reg;
  logic       enable_reg;
  logic       rise_flag_reg;
  logic       fall_flag_reg;
  logic [3:0] hyst_reg;
  logic [7:0] settle_cnt_reg;
  logic       out_state;
  logic       rise_evt;
  logic       fall_evt;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= cmp_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // Disabled comparator reads and routes low
  assign out_state = enable_reg & sync2_reg;

  // Previous output for edge detection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= out_state;
    end
  end

  // Edges only while enabled, so disable suspends events
  assign rise_evt = enable_reg & out_state & ~prev_reg;
  assign fall_evt = enable_reg & ~out_state & prev_reg;

  // Enable and hysteresis stored as written
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enable_reg <= 1'b0;
      hyst_reg   <= 4'h0;
    end else if (wr_en) begin
      enable_reg <= wr_data[dcc_pkg::ENABLE_BIT];
      hyst_reg   <= wr_data[dcc_pkg::POS_HYST_MSB:dcc_pkg::NEG_HYST_LSB];
    end
  end

  // Sticky flags; a same-cycle edge beats a software clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rise_flag_reg <= 1'b0;
      fall_flag_reg <= 1'b0;
    end else begin
      if (rise_evt) begin
        rise_flag_reg <= 1'b1;
      end else if (wr_en) begin
        rise_flag_reg <= wr_data[dcc_pkg::RISE_BIT];
      end
      if (fall_evt) begin
        fall_flag_reg <= 1'b1;
      end else if (wr_en) begin
        fall_flag_reg <= wr_data[dcc_pkg::FALL_BIT];
      end
    end
  end

  // Settling window hint for software after enable
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      settle_cnt_reg <= 8'h00;
    end else if (wr_en && wr_data[dcc_pkg::ENABLE_BIT] && !enable_reg) begin
      settle_cnt_reg <= 8'(dcc_pkg::SETTLE_CYCLES);
    end else if (settle_cnt_reg != 8'h00) begin
      settle_cnt_reg <= settle_cnt_reg - 8'h01;
    end
  end

  assign settling     = (settle_cnt_reg != 8'h00);
  assign routed_out   = out_state;
  assign pos_hyst_sel = hyst_reg[dcc_pkg::POS_HYST_MSB:dcc_pkg::POS_HYST_LSB];
  assign neg_hyst_sel = hyst_reg[dcc_pkg::NEG_HYST_MSB:dcc_pkg::NEG_HYST_LSB];
  // Output bit comes from hardware, writes never reach it
  assign ctrl_rd = {enable_reg, out_state, rise_flag_reg, fall_flag_reg, hyst_reg};

  property p_rise_sets;
    @(posedge ref_clk) disable iff (rst) rise_evt |=> rise_flag_reg;
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rise flag not set");

  property p_fall_sets;
    @(posedge ref_clk) disable iff (rst) fall_evt |=> fall_flag_reg;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("fall flag not set");

  property p_disabled_low;
    @(posedge ref_clk) disable iff (rst) !enable_reg |-> !routed_out && !ctrl_rd[6];
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("disabled output high");

  property p_rise_sticky;
    @(posedge ref_clk) disable iff (rst) rise_flag_reg && !wr_en |=> rise_flag_reg;
  endproperty
  a_rise_sticky: assert property (p_rise_sticky) else $error("rise flag dropped");

  property p_fall_sticky;
    @(posedge ref_clk) disable iff (rst) fall_flag_reg && !wr_en |=> fall_flag_reg;
  endproperty
  a_fall_sticky: assert property (p_fall_sticky) else $error("fall flag dropped");

  // Pin reaches the status bit two clocks later; enable is judged at that edge
  property p_out_follows;
    @(posedge ref_clk) disable iff (rst)
      cmp_raw ##1 cmp_raw ##1 enable_reg |-> ctrl_rd[dcc_pkg::OUTPUT_BIT];
  endproperty
  a_out_follows: assert property (p_out_follows) else $error("output not following");

  property p_out_low;
    @(posedge ref_clk) disable iff (rst)
      !cmp_raw |-> ##2 !ctrl_rd[dcc_pkg::OUTPUT_BIT];
  endproperty
  a_out_low: assert property (p_out_low) else $error("output high with input low");

  property p_hyst_write;
    @(posedge ref_clk) disable iff (rst)
      wr_en |=> {pos_hyst_sel, neg_hyst_sel} == $past(wr_data[3:0]);
  endproperty
  a_hyst_write: assert property (p_hyst_write) else $error("hysteresis not stored");
endmodule : dcc_channel

// file: logic/dcc_pkg.sv
package dcc_pkg;
  // Special-function addresses of the two control registers
  localparam logic [7:0] CMP0_CTRL_ADDR = 8'h9E;
  localparam logic [7:0] CMP1_CTRL_ADDR = 8'h9F;
  localparam logic [7:0] CTRL_RESET     = 8'h00;

  // Field positions inside each control register
  localparam int ENABLE_BIT   = 7;
  localparam int OUTPUT_BIT   = 6;
  localparam int RISE_BIT     = 5;
  localparam int FALL_BIT     = 4;
  localparam int POS_HYST_MSB = 3;
  localparam int POS_HYST_LSB = 2;
  localparam int NEG_HYST_MSB = 1;
  localparam int NEG_HYST_LSB = 0;

  // Analog settling after enable, in microseconds
  localparam int SETTLE_US     = 20;
  localparam int CLK_MHZ       = 10;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
endpackage : dcc_pkg

// file: logic/dcc_top.sv
module dcc_top (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  output logic [7:0]      sfr_rdata,
  input  wire logic [1:0] cmp_raw,
  output logic [1:0]      cmp_routed,
  output logic [1:0]      cmp_enable,
  output logic [3:0]      pos_hyst_sel,
  output logic [3:0]      neg_hyst_sel,
  output logic [1:0]      rise_flag,
  output logic [1:0]      fall_flag,
  output logic [1:0]      settling
);
  logic [7:0] ctrl_rd [2];
  logic [1:0] wr_sel;
  logic [7:0] rdata_reg;

  // Address decoding shared by read and write paths
  function automatic logic [1:0] dcc_decode(input logic [7:0] addr);
    if (addr == dcc_pkg::CMP0_CTRL_ADDR) begin
      return 2'h1;
    end else if (addr == dcc_pkg::CMP1_CTRL_ADDR) begin
      return 2'h2;
    end else begin
      return 2'h0;
    end
  endfunction : dcc_decode

  assign wr_sel = sfr_wr ? dcc_decode(sfr_addr) : 2'h0;

  // One channel per comparator
  generate
    for (genvar i = 0; i < 2; i++) begin : g_ch
      dcc_channel i_dcc_channel (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .cmp_raw      (cmp_raw[i]),
        .wr_en        (wr_sel[i]),
        .wr_data      (sfr_wdata),
        .ctrl_rd      (ctrl_rd[i]),
        .routed_out   (cmp_routed[i]),
        .pos_hyst_sel (pos_hyst_sel[2*i+1:2*i]),
        .neg_hyst_sel (neg_hyst_sel[2*i+1:2*i]),
        .settling     (settling[i])
      );
      assign cmp_enable[i] = ctrl_rd[i][dcc_pkg::ENABLE_BIT];
      assign rise_flag[i]  = ctrl_rd[i][dcc_pkg::RISE_BIT];
      assign fall_flag[i]  = ctrl_rd[i][dcc_pkg::FALL_BIT];
    end
  endgenerate

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_reg <= dcc_pkg::CTRL_RESET;
    end else if (sfr_rd) begin
      if (dcc_decode(sfr_addr) == 2'h1) begin
        rdata_reg <= ctrl_rd[0];
      end else if (dcc_decode(sfr_addr) == 2'h2) begin
        rdata_reg <= ctrl_rd[1];
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end
  assign sfr_rdata = rdata_reg;

  property p_reset_zero;
    @(posedge ref_clk) rst |=> ctrl_rd[1] == 8'h00 && ctrl_rd[0] == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("register not reset");

  property p_read0;
    @(posedge ref_clk) disable iff (rst)
      sfr_rd && sfr_addr == 8'h9E |=> sfr_rdata == $past(ctrl_rd[0]);
  endproperty
  a_read0: assert property (p_read0) else $error("read of comparator 0 wrong");

  property p_flag_write;
    @(posedge ref_clk) disable iff (rst)
      sfr_wr && sfr_addr == 8'h9F && !sfr_wdata[5] && !cmp_routed[1] && !$past(cmp_routed[1])
      ##1 !cmp_routed[1] |-> !rise_flag[1];
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("rise flag clear lost");

  property p_read1;
    @(posedge ref_clk) disable iff (rst)
      sfr_rd && sfr_addr == dcc_pkg::CMP1_CTRL_ADDR |=> sfr_rdata == $past(ctrl_rd[1]);
  endproperty
  a_read1: assert property (p_read1) else $error("read of comparator 1 wrong");

  // Unmapped reads return zero so software never sees stale data
  property p_read_unmapped;
    @(posedge ref_clk) disable iff (rst)
      sfr_rd && sfr_addr != dcc_pkg::CMP0_CTRL_ADDR && sfr_addr != dcc_pkg::CMP1_CTRL_ADDR
      |=> sfr_rdata == 8'h00;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

  // Read data stands until the next read strobe
  property p_rdata_hold;
    @(posedge ref_clk) disable iff (rst) !sfr_rd |=> $stable(sfr_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed");

  // Writes to other addresses leave the stored fields alone
  property p_wr_unmapped;
    @(posedge ref_clk) disable iff (rst)
      sfr_wr && sfr_addr != dcc_pkg::CMP0_CTRL_ADDR && sfr_addr != dcc_pkg::CMP1_CTRL_ADDR
      |=> $stable({cmp_enable, pos_hyst_sel, neg_hyst_sel});
  endproperty
  a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write landed");
endmodule : dcc_top

// file: verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk;
  logic       rst;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic [1:0] cmp_raw;
  logic [1:0] cmp_routed;
  logic [1:0] cmp_enable;
  logic [3:0] pos_hyst_sel;
  logic [3:0] neg_hyst_sel;
  logic [1:0] rise_flag;
  logic [1:0] fall_flag;
  logic [1:0] settling;
  int         error_cnt = 0;
  int         n_compared = 0;

  dcc_top i_dcc_top (
    .ref_clk(ref_clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .cmp_raw(cmp_raw), .cmp_routed(cmp_routed), .cmp_enable(cmp_enable),
    .pos_hyst_sel(pos_hyst_sel), .neg_hyst_sel(neg_hyst_sel),
    .rise_flag(rise_flag), .fall_flag(fall_flag), .settling(settling)
  );

  // Free-running 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Strobes dropped a full cycle later, so each access is one clean pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic chk_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    chk(what, exp, sfr_rdata);
  endtask : chk_reg

  // Raw change, then room for the two-stage synchroniser and flag update
  task automatic drive_raw(input int ch, input logic v);
    @(negedge ref_clk);
    cmp_raw[ch] = v;
    repeat (5) @(negedge ref_clk);
  endtask : drive_raw

  task automatic t_reset;
    chk_reg("ctrl0", 8'h9E, 8'h00);
    chk_reg("ctrl1", 8'h9F, 8'h00);
    chk_reg("unmapped", 8'hA0, 8'h00);
    wr(8'hA0, 8'hFF);
    chk_reg("ctrl0 stray", 8'h9E, 8'h00);
  endtask : t_reset

  // Every hysteresis code on both channels, with the read-only bit poked
  task automatic t_hyst;
    logic [1:0] c;
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = 0; i < 4; i++) begin
        c = 2'(i);
        wr(8'h9E + 8'(ch), {4'h4, c, ~c});
        chk("pos", {6'h00, c}, {6'h00, pos_hyst_sel[2*ch +: 2]});
        chk("neg", {6'h00, ~c}, {6'h00, neg_hyst_sel[2*ch +: 2]});
        chk_reg("ctrl hyst", 8'h9E + 8'(ch), {4'h0, c, ~c});
      end
      wr(8'h9E + 8'(ch), 8'h30);
      chk("rise sw", 8'h01, {7'h00, rise_flag[ch]});
      chk_reg("ctrl sw flags", 8'h9E + 8'(ch), 8'h30);
      wr(8'h9E + 8'(ch), 8'h00);
      chk_reg("ctrl cleared", 8'h9E + 8'(ch), 8'h00);
    end
  endtask : t_hyst

  task automatic t_edges(input int ch);
    logic [7:0] a;
    a = 8'h9E + 8'(ch);
    wr(a, 8'h80);
    chk("enable on", 8'h01, {7'h00, cmp_enable[ch]});
    chk("settling", 8'h01, {7'h00, settling[ch]});
    // Software leaves output and flags alone until the settling time is over
    repeat (199) @(negedge ref_clk);
    chk("settling end", 8'h01, {7'h00, settling[ch]});
    @(negedge ref_clk);
    chk("settled", 8'h00, {7'h00, settling[ch]});
    drive_raw(ch, 1'b1);
    chk("routed hi", 8'h01, {7'h00, cmp_routed[ch]});
    chk_reg("ctrl rise", a, 8'hE0);
    drive_raw(ch, 1'b0);
    chk_reg("ctrl fall", a, 8'hB0);
    wr(a, 8'h80);
    chk_reg("ctrl clr", a, 8'h80);
    drive_raw(ch, 1'b1);
    chk_reg("ctrl rise again", a, 8'hE0);
    // Disabled: toggling must not reach the pin or the flags
    wr(a, 8'h00);
    chk("routed off", 8'h00, {7'h00, cmp_routed[ch]});
    chk("enable off", 8'h00, {7'h00, cmp_enable[ch]});
    drive_raw(ch, 1'b0);
    drive_raw(ch, 1'b1);
    drive_raw(ch, 1'b0);
    chk("flags off", 8'h00, {6'h00, rise_flag[ch], fall_flag[ch]});
    chk_reg("ctrl off", a, 8'h00);
  endtask : t_edges

  // Reset in mid-run clears both registers and every output
  task automatic t_mid_reset;
    wr(8'h9E, 8'hBF);
    wr(8'h9F, 8'hFF);
    chk("en before rst", 8'h03, {6'h00, cmp_enable});
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    chk("outs after rst", 8'h00, {cmp_enable, rise_flag, fall_flag, settling});
    chk("hyst after rst", 8'h00, {pos_hyst_sel, neg_hyst_sel});
    chk_reg("ctrl0 after rst", 8'h9E, 8'h00);
    chk_reg("ctrl1 after rst", 8'h9F, 8'h00);
  endtask : t_mid_reset

  task automatic end_of_test;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Watchdog, far beyond the six hundred or so cycles the tests need
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    cmp_raw = 2'h0;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    t_reset();
    t_hyst();
    t_edges(0);
    t_edges(1);
    t_mid_reset();
    end_of_test();
  end
endmodule : tb
